//--- bcc_params.svh
// Register offsets, field positions, reset values and timing counts of the charge-cycle controller
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
// Register byte offsets
`define BCC_ADDR_CTRL      8'h00
`define BCC_ADDR_VOLT      8'h04
`define BCC_ADDR_CURR      8'h08
`define BCC_ADDR_TERM      8'h0c
`define BCC_ADDR_TIMER     8'h10
`define BCC_ADDR_STATUS    8'h14
// Control word bit positions
`define BCC_CTRL_CHGEN     0
`define BCC_CTRL_TERMEN    1
`define BCC_CTRL_SWOFF     2
`define BCC_CTRL_RECHSEL   3
`define BCC_CTRL_WARMSEL   4
`define BCC_CTRL_COOLSEL   5
`define BCC_CTRL_STATLSB   6
`define BCC_CTRL_TOPLSB    8
`define BCC_CTRL_REGRST    10
// Upper half-word field position in the current registers
`define BCC_HI_LSB         16
// Reset values of the settings
`define BCC_RST_CHGEN      1'b1
`define BCC_RST_TERMEN     1'b1
`define BCC_RST_REGULATION_VOLTAGE_SETTING_MV    13'h1070
`define BCC_RST_FAST_MA    12'h800
`define BCC_RST_PRE_MA     12'h0b4
`define BCC_RST_TERM_MA    12'h0b4
`define BCC_RST_SHORT_MA   12'h064
`define BCC_RST_HOURS      4'ha
// Temperature-zone limits
`define BCC_WARM_MV        13'h1004
`define BCC_COOL_PCT       24'h000014
`define BCC_PCT_FULL       24'h000064
// Timing
`define BCC_CLK_HZ         40000000
`define BCC_TICK_MS        1000
`define BCC_BLINK_MS       500
`define BCC_TICK_CYCLES    (`BCC_CLK_HZ / 1000 * `BCC_TICK_MS)
`define BCC_BLINK_CYCLES   (`BCC_CLK_HZ / 1000 * `BCC_BLINK_MS)
`define BCC_TOPOFF1_S      900
`define BCC_TOPOFF2_S      1800
`define BCC_TOPOFF3_S      2700
`endif

//--- bcc_pkg.sv
// Types shared by the charge-cycle controller
package bcc_pkg;
    // Comparator and pin levels from the analog side, all asynchronous
    typedef struct packed {
        logic       ceN;            // Charge enable pin, active low
        logic       convRun;        // Converter is running
        logic       above2v2;       // Battery above 2.2 V
        logic       above3v;        // Battery above 3 V
        logic       belowTerm;      // Charge current below termination level
        logic       aboveRech0;     // Battery above recharge threshold, choice 0
        logic       aboveRech1;     // Battery above recharge threshold, choice 1
        logic       inputLimit;     // Input power limiting active
        logic       thermalReg;     // Thermal regulation active
        logic       tsInWindow;     // Thermistor between T1 and T5
        logic       tsCool;         // Thermistor in T1..T2
        logic       tsWarm;         // Thermistor in T3..T5
        logic       safetyExpired;  // Safety timer has expired
        logic       supplementReq;  // Supplement operation wanted
        logic       boostReq;       // Boost requested
        logic       tsBoostOk;      // Thermistor inside boost range
        logic [2:0] inputType;      // Detected input type
    } bcc_sense_t;
    // Settings to the analog loops and neighbours
    typedef struct packed {
        logic        chargeOn;      // Charging current allowed
        logic [11:0] currentMa;     // Charge current target
        logic [12:0] voltageMv;     // Charge voltage target
        logic [11:0] termMa;        // Termination current level
        logic [3:0]  safetyHours;   // Safety timer length
        logic        safetyPause;   // Safety timer paused
        logic        safetyHalf;    // Safety timer at half rate
        logic        safetyRestart; // Safety timer restart pulse
        logic        batterySwitchOn; // Battery switch closed
        logic        boostRun;      // Boost converter may run
    } bcc_drive_t;
    // Software settings
    typedef struct packed {
        logic       chgEn;  logic termEn;  logic swOff;  logic rechSel;
        logic       warmSel; logic coolSel; logic [1:0] statCtl; logic [1:0] topSel;
        logic [12:0] vregMv; logic [11:0] fastMa; logic [11:0] preMa;
        logic [11:0] termMa; logic [11:0] shortMa; logic [3:0] hours;
    } bcc_regs_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001, ST_PRE = 5'b00010, ST_FAST = 5'b00100,
        ST_TOPOFF = 5'b01000, ST_DONE = 5'b10000
    } bcc_fsm_t;
    // Whole state of the controller
    typedef struct packed {
        bcc_sense_t  syncA;      bcc_sense_t syncB;   bcc_fsm_t fsm;   bcc_regs_t regs;
        logic [31:0] tickCnt;    logic halfPh;        logic [15:0] topCnt;  logic [1:0] topDur;
        logic [31:0] blinkCnt;   logic blinkPh;       logic enPrev;   logic safetyPrev;
        logic [1:0]  phase;      logic [1:0] fault;   logic thermFault; logic [2:0] inputType;
        logic        intPulse;   logic statO;         logic statOe;   bcc_drive_t drv;
        logic [31:0] prdata;     logic pready;        logic pslverr;
    } bcc_state_t;
endpackage : bcc_pkg

//--- bcc_charge_ctrl.sv
// Charge-cycle controller of a single-cell charger with APB register access
//
// Operation
// - Charge autonomously while bit set and pin low
// - Reset defaults: 4.208V, 2.048A, 180mA, 10h
// - Start needs converter, enable, current, no faults
// - Terminate on low current, high voltage, unregulated
// - Recharge below selected threshold after done
// - Toggling enable pin or bit restarts charging
// - Indicator low charging, high done, blinks fault
// - Indicator disabled when control field is 11
// - Phase field: 00 off,01 pre,10 fast,11 done
// - Termination sets phase 11 and pulses interrupt
// - Start current chosen from battery voltage bands
// - Regulation suppresses termination, halves timer rate
// - Battery switch opens after completed cycle
// - Termination enable cleared prevents termination
// - Top-off timer pauses and halves with safety timer
// - Readable top-off running flag
// - Top-off timer cleared on enable, termination, reset
// - Top-off duration latched at termination
// - Interrupt on top-off entry and expiry
// - Charge only inside thermistor window, else suspend
// - Warm voltage 4.1V option, cool current 20%
// - Boost suspended on temperature fault, type 000
// - Safety expiry sets fault 11, pulses interrupt
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "bcc_params.svh"
module bcc_charge_ctrl
    import bcc_pkg::*;
#(
    parameter int TICK_CYCLES  = `BCC_TICK_CYCLES,  // Cycles per top-off timer second
    parameter int BLINK_CYCLES = `BCC_BLINK_CYCLES, // Cycles per indicator half period
    parameter int TOPOFF1_S    = `BCC_TOPOFF1_S,    // Top-off length, choice 1
    parameter int TOPOFF2_S    = `BCC_TOPOFF2_S,    // Top-off length, choice 2
    parameter int TOPOFF3_S    = `BCC_TOPOFF3_S     // Top-off length, choice 3
) (
    input  wire logic        clk_sys,   // System clock, 40 MHz
    input  wire logic        rstn,      // Synchronous reset, active low
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB enable
    input  wire logic        pwrite,    // APB direction
    input  wire logic [7:0]  paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error on unmapped address
    input  wire bcc_sense_t  senseIn,   // Analog comparator and pin levels
    output bcc_drive_t       drvOut,    // Settings to analog loops
    output logic             intPulse,  // One-cycle interrupt pulse
    output logic             statO,     // Indicator pin output value
    output logic             statOe     // Indicator pin output enable
);
    localparam logic [31:0] TICK_LAST  = 32'(TICK_CYCLES - 1);
    localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYCLES - 1);
    // Settings after reset or a register reset command
    localparam bcc_regs_t REGS_RST = '{
        chgEn: `BCC_RST_CHGEN, termEn: `BCC_RST_TERMEN, swOff: 1'b0, rechSel: 1'b0,
        warmSel: 1'b0, coolSel: 1'b0, statCtl: 2'h0, topSel: 2'h0,
        vregMv: `BCC_RST_REGULATION_VOLTAGE_SETTING_MV, fastMa: `BCC_RST_FAST_MA, preMa: `BCC_RST_PRE_MA,
        termMa: `BCC_RST_TERM_MA, shortMa: `BCC_RST_SHORT_MA, hours: `BCC_RST_HOURS};

    bcc_state_t  s;           // Registered state
    bcc_state_t  n;           // Next state
    bcc_sense_t  sn;          // Synchronised analog levels
    logic        enabled;     // Charging allowed by bit, pin and converter
    logic        rechAbove;   // Battery above the selected recharge threshold
    logic        regulating;  // Input limiting or thermal regulation
    logic        halfRate;    // Timers run at half rate
    logic        paused;      // Timers stand still
    logic        startOk;     // New cycle may begin
    logic        termNow;     // Termination condition met
    logic        tick;        // One timer second elapsed
    logic        advance;     // Top-off timer advances this cycle
    logic        charging;    // A charging phase is active
    logic        faultOn;     // Indicator should blink
    logic        setupCyc;    // APB setup phase seen
    logic        accessCyc;   // APB access completes this edge
    logic [15:0] topLimit;    // Latched top-off length in seconds

    assign sn = s.syncB;

    // Condition terms, from registered state except the APB phase terms, which use psel and penable
    assign enabled    = s.regs.chgEn && !sn.ceN && sn.convRun;
    assign rechAbove  = s.regs.rechSel ? sn.aboveRech1 : sn.aboveRech0;
    assign regulating = sn.inputLimit || sn.thermalReg;
    assign halfRate   = regulating || sn.tsCool;
    assign paused     = !sn.tsInWindow;
    assign startOk    = enabled && (s.regs.fastMa != 12'h000) && sn.tsInWindow
                        && !sn.safetyExpired && !s.regs.swOff;
    // Termination is held off under regulation or when software disabled it
    assign termNow    = sn.belowTerm && rechAbove && !regulating && s.regs.termEn;
    assign tick       = (s.tickCnt == TICK_LAST);
    assign advance    = tick && !paused && (!halfRate || s.halfPh);
    assign charging   = (s.fsm == ST_PRE) || (s.fsm == ST_FAST) || (s.fsm == ST_TOPOFF);
    assign faultOn    = (s.fault != 2'h0) || (charging && !sn.tsInWindow);
    assign setupCyc   = psel && !penable;
    assign accessCyc  = psel && penable && s.pready;

    // Top-off length chosen when termination was detected
    always_comb begin
        case (s.topDur)
            2'h1:    topLimit = 16'(TOPOFF1_S);
            2'h2:    topLimit = 16'(TOPOFF2_S);
            2'h3:    topLimit = 16'(TOPOFF3_S);
            default: topLimit = 16'h0001;
        endcase
    end

    // Next-state logic for the whole controller
    always_comb begin
        n = s;
        // Two-stage synchronisers; only the second stage is used
        n.syncA = senseIn;
        n.syncB = s.syncA;
        n.intPulse = 1'b0;
        n.drv.safetyRestart = 1'b0;
        n.enPrev = enabled;
        n.safetyPrev = sn.safetyExpired;

        // Timer second prescaler and half-rate phase
        if (tick) begin
            n.tickCnt = '0;
        end else begin
            n.tickCnt = s.tickCnt + 32'h1;
        end
        if (!halfRate) begin
            n.halfPh = 1'b0;
        end else if (tick && !paused) begin
            n.halfPh = !s.halfPh;
        end

        // A fresh enable clears the top-off timer and old faults
        if (enabled && !s.enPrev) begin
            n.topCnt = '0;
            n.fault = 2'h0;
        end

        // Charge cycle sequencing
        case (s.fsm)
            ST_IDLE: begin
                if (startOk) begin
                    n.drv.safetyRestart = 1'b1;
                    n.fsm = sn.above3v ? ST_FAST : ST_PRE;
                end
            end
            ST_PRE: begin
                if (!enabled) begin
                    n.fsm = ST_IDLE;
                end else if (sn.above3v) begin
                    n.fsm = ST_FAST;
                end
            end
            ST_FAST: begin
                if (!enabled) begin
                    n.fsm = ST_IDLE;
                end else if (termNow) begin
                    // Duration frozen here; later writes wait for the next cycle
                    n.topDur = s.regs.topSel;
                    n.topCnt = '0;
                    n.intPulse = 1'b1;
                    n.fsm = (s.regs.topSel != 2'h0) ? ST_TOPOFF : ST_DONE;
                end
            end
            ST_TOPOFF: begin
                if (!enabled) begin
                    n.fsm = ST_IDLE;
                end else if (advance) begin
                    if (s.topCnt + 16'h1 >= topLimit) begin
                        n.intPulse = 1'b1;
                        n.fsm = ST_DONE;
                    end else begin
                        n.topCnt = s.topCnt + 16'h1;
                    end
                end
            end
            ST_DONE: begin
                if (!enabled) begin
                    n.fsm = ST_IDLE;
                end else if (!rechAbove && startOk) begin
                    // Battery sagged: begin a recharge on our own
                    n.drv.safetyRestart = 1'b1;
                    n.fsm = sn.above3v ? ST_FAST : ST_PRE;
                end
            end
            default: begin
                n.fsm = ST_IDLE;
            end
        endcase

        // Safety timer expiry ends the cycle with a fault
        if (charging && enabled && sn.safetyExpired && !s.safetyPrev) begin
            n.fault = 2'h3;
            n.intPulse = 1'b1;
            n.fsm = ST_IDLE;
        end

        // Phase field follows the sequencer
        case (n.fsm)
            ST_PRE:    n.phase = 2'h1;
            ST_FAST:   n.phase = 2'h2;
            ST_TOPOFF: n.phase = 2'h3;
            ST_DONE:   n.phase = 2'h3;
            default:   n.phase = 2'h0;
        endcase

        // Analog targets; current band rechecked while in precharge
        n.drv.chargeOn = charging && sn.tsInWindow;
        if (s.fsm == ST_PRE) begin
            n.drv.currentMa = sn.above2v2 ? s.regs.preMa : s.regs.shortMa;
        end else if (sn.tsCool && s.regs.coolSel) begin
            n.drv.currentMa = 12'((24'(s.regs.fastMa) * `BCC_COOL_PCT) / `BCC_PCT_FULL);
        end else begin
            n.drv.currentMa = s.regs.fastMa;
        end
        n.drv.voltageMv = (sn.tsWarm && s.regs.warmSel) ? `BCC_WARM_MV : s.regs.vregMv;
        n.drv.termMa = s.regs.termMa;
        n.drv.safetyHours = s.regs.hours;
        n.drv.safetyPause = paused;
        // Both timers halve together, cool zone included, so top-off tracks the safety timer
        n.drv.safetyHalf = halfRate;
        // Switch opens once done, but closes again for supplement
        n.drv.batterySwitchOn = !s.regs.swOff && ((s.fsm != ST_DONE) || sn.supplementReq);

        // Boost is held off outside its temperature range
        n.thermFault = sn.boostReq && !sn.tsBoostOk;
        n.drv.boostRun = sn.boostReq && sn.tsBoostOk;
        n.inputType = (sn.boostReq && !sn.tsBoostOk) ? 3'h0 : sn.inputType;

        // Indicator: open drain, drives low in the blink phase on a fault, else while charging
        if (s.blinkCnt == BLINK_LAST) begin
            n.blinkCnt = '0;
            n.blinkPh = !s.blinkPh;
        end else begin
            n.blinkCnt = s.blinkCnt + 32'h1;
        end
        n.statO = 1'b0;
        n.statOe = (s.regs.statCtl != 2'h3)
                   && (faultOn ? s.blinkPh : charging);

        // APB slave: answer in the access phase following setup
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (setupCyc) begin
            n.pready = 1'b1;
            n.prdata = 32'h0;
            case (paddr)
                `BCC_ADDR_CTRL:   n.prdata = {21'h0, 1'b0, s.regs.topSel, s.regs.statCtl, s.regs.coolSel,
                                              s.regs.warmSel, s.regs.rechSel, s.regs.swOff,
                                              s.regs.termEn, s.regs.chgEn};
                `BCC_ADDR_VOLT:   n.prdata = {19'h0, s.regs.vregMv};
                `BCC_ADDR_CURR:   n.prdata = {4'h0, s.regs.preMa, 4'h0, s.regs.fastMa};
                `BCC_ADDR_TERM:   n.prdata = {4'h0, s.regs.shortMa, 4'h0, s.regs.termMa};
                `BCC_ADDR_TIMER:  n.prdata = {28'h0, s.regs.hours};
                `BCC_ADDR_STATUS: n.prdata = {22'h0, s.drv.batterySwitchOn, s.inputType, s.thermFault,
                                              (s.fsm == ST_TOPOFF), s.fault, s.phase};
                default:          n.pslverr = 1'b1;
            endcase
        end
        if (accessCyc && pwrite) begin
            case (paddr)
                `BCC_ADDR_CTRL: begin
                    if (pwdata[`BCC_CTRL_REGRST]) begin
                        n.regs = REGS_RST;
                        n.topCnt = '0;
                    end else begin
                        n.regs.chgEn   = pwdata[`BCC_CTRL_CHGEN];
                        n.regs.termEn  = pwdata[`BCC_CTRL_TERMEN];
                        n.regs.swOff   = pwdata[`BCC_CTRL_SWOFF];
                        n.regs.rechSel = pwdata[`BCC_CTRL_RECHSEL];
                        n.regs.warmSel = pwdata[`BCC_CTRL_WARMSEL];
                        n.regs.coolSel = pwdata[`BCC_CTRL_COOLSEL];
                        n.regs.statCtl = pwdata[`BCC_CTRL_STATLSB +: 2];
                        n.regs.topSel  = pwdata[`BCC_CTRL_TOPLSB +: 2];
                    end
                end
                `BCC_ADDR_VOLT: n.regs.vregMv = pwdata[12:0];
                `BCC_ADDR_CURR: begin
                    n.regs.fastMa = pwdata[11:0];
                    n.regs.preMa  = pwdata[`BCC_HI_LSB +: 12];
                end
                `BCC_ADDR_TERM: begin
                    n.regs.termMa  = pwdata[11:0];
                    n.regs.shortMa = pwdata[`BCC_HI_LSB +: 12];
                end
                `BCC_ADDR_TIMER: n.regs.hours = pwdata[3:0];
                default: begin
                    n.regs = s.regs;  // Status and unmapped words ignore writes
                end
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s <= '0;
            s.regs <= REGS_RST;
            s.fsm <= ST_IDLE;
            s.syncA.ceN <= 1'b1;
            s.syncB.ceN <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state register
    assign prdata   = s.prdata;
    assign pready   = s.pready;
    assign pslverr  = s.pslverr;
    assign drvOut   = s.drv;
    assign intPulse = s.intPulse;
    assign statO    = s.statO;
    assign statOe   = s.statOe;

    // Checks on the sequencer and its outputs
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    phase_code_a: assert property ((s.fsm == ST_PRE) |-> (s.phase == 2'h1))
        else $error("phase field not 01 in precharge");
    fast_code_a: assert property ((s.fsm == ST_FAST) |-> (s.phase == 2'h2))
        else $error("phase field not 10 in fast charge");
    start_gate_a: assert property ((s.fsm == ST_IDLE) && !startOk |=> (s.fsm == ST_IDLE))
        else $error("cycle started without all start conditions");
    term_block_a: assert property ((s.fsm == ST_FAST) && regulating |=> (s.fsm inside {ST_FAST, ST_IDLE}))
        else $error("termination during regulation");
    term_event_a: assert property ((s.fsm == ST_FAST) ##1 (s.fsm == ST_DONE) |-> s.intPulse && (s.phase == 2'h3))
        else $error("termination without phase 11 and pulse");
    stat_off_a: assert property ((s.regs.statCtl == 2'h3) |=> !statOe)
        else $error("indicator driven while disabled");
    switch_off_a: assert property ((s.fsm == ST_DONE) && !sn.supplementReq |=> !drvOut.batterySwitchOn)
        else $error("battery switch on after done");
    safety_fault_a: assert property (charging && enabled && sn.safetyExpired && !s.safetyPrev
                                     |=> (s.fault == 2'h3) && s.intPulse && (s.fsm == ST_IDLE))
        else $error("safety expiry not reported");
    boost_fault_a: assert property (sn.boostReq && !sn.tsBoostOk
                                    |=> (s.inputType == 3'h0) && s.thermFault && !drvOut.boostRun)
        else $error("boost not suspended on temperature fault");
    ts_suspend_a: assert property (charging && !sn.tsInWindow |=> !drvOut.chargeOn)
        else $error("charging outside thermistor window");
    short_cur_a: assert property ((s.fsm == ST_PRE) && !sn.above2v2 |=> drvOut.currentMa == $past(s.regs.shortMa))
        else $error("short battery current not selected");
    topoff_end_a: assert property ((s.fsm == ST_TOPOFF) && enabled && advance && (s.topCnt + 16'h1 >= topLimit)
                                   && !(sn.safetyExpired && !s.safetyPrev) |=> (s.fsm == ST_DONE) && s.intPulse)
        else $error("top-off expiry not handled");
    // Timers, software settings and status reporting
    term_hold_a: assert property ((s.fsm == ST_FAST) && !s.regs.termEn |=> (s.phase != 2'h3))
        else $error("termination while disabled");
    top_pause_a: assert property ((s.fsm == ST_TOPOFF) && paused && !accessCyc |=> $stable(s.topCnt))
        else $error("top-off ran while paused");
    top_half_a: assert property ((s.fsm == ST_TOPOFF) && halfRate && !s.halfPh && !accessCyc
                                 |=> $stable(s.topCnt))
        else $error("top-off ran at full rate");
    half_rate_a: assert property (halfRate |=> drvOut.safetyHalf)
        else $error("safety timer not halved");
    top_flag_a: assert property ((s.fsm == ST_TOPOFF) && setupCyc && (paddr == `BCC_ADDR_STATUS)
                                 |=> prdata[4])
        else $error("top-off flag not read");
    reg_reset_a: assert property (accessCyc && pwrite && (paddr == `BCC_ADDR_CTRL) && pwdata[`BCC_CTRL_REGRST]
                                  |=> (s.regs == REGS_RST) && (s.topCnt == 16'h0))
        else $error("register reset incomplete");
    warm_volt_a: assert property (sn.tsWarm && s.regs.warmSel |=> (drvOut.voltageMv == `BCC_WARM_MV))
        else $error("warm voltage not applied");
    restart_a: assert property ((s.fsm == ST_IDLE) && startOk |=> drvOut.safetyRestart)
        else $error("safety timer not restarted");

    topoff_done_c: cover property ((s.fsm == ST_TOPOFF) ##1 (s.fsm == ST_DONE));
    recharge_c: cover property ((s.fsm == ST_DONE) ##1 (s.fsm inside {ST_PRE, ST_FAST}));
    blink_c: cover property ((s.fault == 2'h3) && statOe);
    boost_fault_c: cover property (s.thermFault);
    topoff_entry_c: cover property ((s.fsm == ST_FAST) ##1 (s.fsm == ST_TOPOFF));
endmodule : bcc_charge_ctrl

//--- bcc_batt_model.sv
// Battery and thermistor model facing the charge-cycle controller
`timescale 1ns/1ps
module bcc_batt_model
    import bcc_pkg::*;
#(
    parameter int RECH0_MV = 4100, // Recharge threshold, choice 0
    parameter int RECH1_MV = 4000  // Recharge threshold, choice 1
) (
    input  wire logic        clk_sys,  // System clock
    input  wire bcc_sense_t  envIn,    // Pin, regulation and thermistor levels
    input  wire logic [12:0] battMv,   // Battery voltage in mV
    output bcc_sense_t       senseOut  // Comparator levels to the controller
);
    // Comparators refresh on the edge; current tapers to the end level only near full charge
    always_ff @(posedge clk_sys) begin
        senseOut            <= envIn;
        senseOut.above2v2   <= battMv > 13'd2200;
        senseOut.above3v    <= battMv > 13'd3000;
        senseOut.belowTerm  <= battMv >= 13'd4200;
        senseOut.aboveRech0 <= battMv > 13'(RECH0_MV);
        senseOut.aboveRech1 <= battMv > 13'(RECH1_MV);
    end
endmodule : bcc_batt_model

//--- battery_charge_cycle_controller_tb.sv
// Self-checking bench of the charge-cycle controller
`timescale 1ns/1ps
`define CHK(nm, e, s) begin nChecks++; if ((s) !== (e)) begin nErrors++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module battery_charge_cycle_controller_tb;
    import bcc_pkg::*;
    logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, intPulse, statO, statOe;
    logic [7:0]  paddr = '0;  // APB byte address
    logic [31:0] pwdata = '0, prdata, rd;
    logic [12:0] battMv = 13'd3500;  // Battery voltage
    bcc_sense_t  envS = '0, senseS;
    bcc_drive_t  drvS;
    int nErrors = 0, nChecks = 0, intCnt = 0, cyc = 0, base, e;
    always #12.5 clk_sys = ~clk_sys;
    bcc_batt_model batt_u (.clk_sys(clk_sys), .envIn(envS), .battMv(battMv), .senseOut(senseS));
    bcc_charge_ctrl #(.TICK_CYCLES(4), .BLINK_CYCLES(8), .TOPOFF1_S(2), .TOPOFF2_S(3), .TOPOFF3_S(4)) dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .senseIn(senseS),
        .drvOut(drvS), .intPulse(intPulse), .statO(statO), .statOe(statOe));
    // Interrupt pulses counted here; a hang is cut short by the cycle ceiling
    always @(posedge clk_sys) begin
        if (intPulse === 1'b1) intCnt++;
        if (++cyc == 6000) begin nErrors++; finishTest(); end
    end
    // One APB transfer: setup, then access held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task finishTest;
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finishTest
    logic [7:0]  rAddr [4] = '{8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] rExp  [4] = '{32'h1070, 32'h00b40800, 32'h006400b4, 32'ha};
    initial begin
        void'($urandom(32'hb8d5e126));
        envS.convRun <= 1; envS.tsInWindow <= 1; envS.inputType <= 3'h1;  // Pin low enables charging
        repeat (6) @(posedge clk_sys);
        rstn <= 1;
        apb(0, 8'h00, 0); `CHK("ctrl", 32'h3, rd)
        foreach (rAddr[i]) begin apb(0, rAddr[i], 0); `CHK("dflt", rExp[i], rd) end
        apb(0, 8'h18, 0); `CHK("slverr", 1, e)
        repeat (8) @(posedge clk_sys);
        apb(0, 8'h14, 0); `CHK("fast", 2'b10, rd[1:0])
        `CHK("ledOn", 1'b1, statOe)
        // Random start voltages across the short, precharge and fast bands
        repeat (4) begin
            apb(1, 8'h00, 32'h2); repeat (8) @(posedge clk_sys);
            apb(0, 8'h14, 0); `CHK("off", 2'b00, rd[1:0])
            battMv <= 13'(1500 + $urandom % 2000);
            apb(1, 8'h00, 32'h3); repeat (8) @(posedge clk_sys);
            apb(0, 8'h14, 0); `CHK("start", (battMv > 3000) ? 2'b10 : 2'b01, rd[1:0])
        end
        // Input limiting holds off termination until it clears
        envS.inputLimit <= 1; battMv <= 13'd4300; repeat (12) @(posedge clk_sys);
        apb(0, 8'h14, 0); `CHK("noTerm", 2'b10, rd[1:0])
        base = intCnt; envS.inputLimit <= 0; repeat (10) @(posedge clk_sys);
        apb(0, 8'h14, 0); `CHK("done", 2'b11, rd[1:0])
        `CHK("intr", base + 1, intCnt)
        `CHK("ledOff", 1'b0, statOe)
        `CHK("swOff", 1'b0, drvS.batterySwitchOn)
        `CHK("statO", 1'b0, statO)
        // Top-off segment, with termination first held off by software
        apb(1, 8'h00, 32'h100); apb(1, 8'h00, 32'h101); repeat (8) @(posedge clk_sys);
        apb(0, 8'h14, 0); `CHK("termOff", 2'b10, rd[1:0])
        base = intCnt; apb(1, 8'h00, 32'h103); repeat (2) @(posedge clk_sys);
        apb(0, 8'h14, 0); `CHK("topoff", 5'b10011, rd[4:0])
        repeat (20) @(posedge clk_sys);
        apb(0, 8'h14, 0); `CHK("topEnd", 5'b00011, rd[4:0])
        `CHK("topIntr", base + 2, intCnt)
        finishTest();
    end
endmodule : battery_charge_cycle_controller_tb
